// [shared/basic_up_timer_params.svh]
`ifndef BASIC_UP_TIMER_PARAMS_SVH
`define BASIC_UP_TIMER_PARAMS_SVH
// register byte offsets
`define OFS_CONTROL_ONE 12'h000
`define OFS_CONTROL_TWO 12'h004
`define OFS_IRQ_DMA_ENABLE 12'h00c
`define OFS_STATUS_FLAGS 12'h010
`define OFS_EVENT_GENERATE 12'h014
`define OFS_COUNTER_VALUE 12'h024
`define OFS_PRESCALE_VALUE 12'h028
`define OFS_RELOAD_VALUE 12'h02c
// control_one fields
`define BIT_COUNT_ENABLE 0
`define BIT_UPDATE_DISABLE 1
`define BIT_UPDATE_SOURCE_SELECT 2
`define BIT_ONE_SHOT_ENABLE 3
`define BIT_RELOAD_BUFFER_ENABLE 7
// control_two field
`define MSB_MASTER_OUT_SELECT 6
`define LSB_MASTER_OUT_SELECT 4
// irq_dma_enable fields
`define BIT_UPDATE_IRQ_ENABLE 0
`define BIT_UPDATE_DMA_ENABLE 8
// status and event bits
`define BIT_UPDATE_FLAG 0
`define BIT_FORCE_UPDATE 0
// writable masks and reset values
`define MASK_CONTROL_ONE 16'h008f
`define MASK_CONTROL_TWO 16'h0070
`define MASK_IRQ_DMA_ENABLE 16'h0101
`define RST_CONTROL 16'h0000
`define RST_RELOAD_VALUE 16'hffff
`endif

// [shared/basic_up_timer_pkg.sv]
package basic_up_timer_pkg;
  typedef enum logic [2:0] {
    mo_reset = 3'h0,
    mo_enable = 3'h1,
    mo_update = 3'h2
  } master_out_e;
  typedef logic [15:0] half_t;
endpackage

// [shared/tick_if.sv]
`timescale 1ns/1ps
interface tick_if;
  logic clear;
  logic [15:0] divide;
  logic run;
  logic tick;
  modport owner (output clear, output divide, output run, input tick);
  modport divider (input clear, input divide, input run, output tick);
endinterface

// [core/tick_prescaler.sv]
`timescale 1ns/1ps
`include "basic_up_timer_params.svh"
module tick_prescaler (
  input wire logic pclk,
  input wire logic presetn,
  tick_if.divider tk
);
  import basic_up_timer_pkg::*;
  typedef struct packed {
    logic [15:0] count;
  } state_s;
  state_s st_q;
  state_s st_d;

  // divides pclk by divide+1; clear restarts the division
  always_comb begin
    st_d = st_q;
    tk.tick = 1'b0;
    if (tk.clear) begin
      st_d.count = 16'h0000;
    end else if (tk.run) begin
      if (st_q.count >= tk.divide) begin
        st_d.count = 16'h0000;
        tk.tick = 1'b1;
      end else begin
        st_d.count = st_q.count + 16'h0001;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end
endmodule

// [core/basic_up_timer.sv]
`timescale 1ns/1ps
`include "basic_up_timer_params.svh"
// Functional notes
// - sixteen-bit counter, up counting only
// - wraps to zero after reload, overflow signalled
// - tick equals clock over prescale plus one
// - prescale and reload buffers refresh on update
// - counts only while count enable set
// - update disable suppresses all update events
// - update source selects which events flag
// - one shot clears count enable on update
// - reload buffer bit delays reload writes
// - master out select drives trigger output
// - enable bits gate interrupt and dma
// - update flag set by hardware, write zero clears
// - force update clears prescaler, and counter unless update disable set; self clears
// - reload resets ffff, zero reload halts
// - word spaced registers, counter read write
// - internal clock is the only source
module basic_up_timer (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq,
  output logic dma_req,
  output logic trigger_output
);
  import basic_up_timer_pkg::*;

  typedef struct packed {
    logic [15:0] control_one;
    logic [15:0] control_two;
    logic [15:0] irq_dma_enable;
    logic update_flag;
    logic force_update;
    logic [15:0] counter_value;
    logic [15:0] prescale_value;
    logic [15:0] prescale_active;
    logic [15:0] reload_value;
    logic [15:0] reload_active;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic irq;
    logic dma_req;
    logic trigger_output;
    logic reset_pulse;
  } state_s;

  state_s st_q;
  state_s st_d;
  tick_if tk ();

  logic wr_acc;
  logic rd_acc;
  logic count_tick;
  logic overflow;
  logic soft_update;
  logic update_event_pulse;
  logic update_request;
  logic running;
  logic [15:0] wdata;
  logic [15:0] next_count;
  master_out_e mo_sel;

  tick_prescaler u_prescaler (
    .pclk(pclk),
    .presetn(presetn),
    .tk(tk)
  );

  assign wdata = pwdata[15:0];
  // access phase; slave answers without wait states
  assign wr_acc = psel && penable && pwrite;
  assign rd_acc = psel && penable && !pwrite;
  assign running = st_q.control_one[`BIT_COUNT_ENABLE] && (st_q.reload_active != 16'h0000);
  assign count_tick = tk.tick;
  assign overflow = count_tick && (st_q.counter_value == st_q.reload_active);
  assign soft_update = st_q.force_update;
  assign update_event_pulse = !st_q.control_one[`BIT_UPDATE_DISABLE] &&
                              (overflow || soft_update);
  // source select narrows the request sources
  assign update_request = update_event_pulse &&
                          (overflow || !st_q.control_one[`BIT_UPDATE_SOURCE_SELECT]);
  assign mo_sel = master_out_e'(st_q.control_two[`MSB_MASTER_OUT_SELECT:`LSB_MASTER_OUT_SELECT]);

  // prescaler fed from the active buffer
  always_comb begin
    tk.divide = st_q.prescale_active;
    tk.run = running;
    // force update restarts the prescaler too
    tk.clear = soft_update;
  end

  always_comb begin
    if (overflow) begin
      next_count = 16'h0000;
    end else begin
      next_count = st_q.counter_value + 16'h0001;
    end
  end

  // register file, counter and outputs
  always_comb begin
    st_d = st_q;
    st_d.pready = 1'b0;
    st_d.pslverr = 1'b0;
    st_d.reset_pulse = 1'b0;
    // force update self clears after one cycle
    st_d.force_update = 1'b0;

    // advance only on ticks while enabled
    if (count_tick) begin
      st_d.counter_value = next_count;
    end

    if (psel && !penable) begin
      st_d.pready = 1'b1;
    end

    if (wr_acc && st_q.pready) begin
      case (paddr)
        `OFS_CONTROL_ONE: begin
          st_d.control_one = wdata & `MASK_CONTROL_ONE;
        end
        `OFS_CONTROL_TWO: begin
          st_d.control_two = wdata & `MASK_CONTROL_TWO;
        end
        `OFS_IRQ_DMA_ENABLE: begin
          st_d.irq_dma_enable = wdata & `MASK_IRQ_DMA_ENABLE;
        end
        `OFS_STATUS_FLAGS: begin
          // write zero clears, write one keeps
          if (!wdata[`BIT_UPDATE_FLAG]) begin
            st_d.update_flag = 1'b0;
          end
        end
        `OFS_EVENT_GENERATE: begin
          if (wdata[`BIT_FORCE_UPDATE]) begin
            st_d.force_update = 1'b1;
            st_d.reset_pulse = 1'b1;
          end
        end
        `OFS_COUNTER_VALUE: begin
          st_d.counter_value = wdata;
        end
        `OFS_PRESCALE_VALUE: begin
          st_d.prescale_value = wdata;
        end
        `OFS_RELOAD_VALUE: begin
          st_d.reload_value = wdata;
          if (!st_q.control_one[`BIT_RELOAD_BUFFER_ENABLE]) begin
            st_d.reload_active = wdata;
          end
        end
        default: begin
          // unmapped: the error was already raised in the setup cycle
        end
      endcase
    end

    // read mux; reserved bits and write-only registers read zero
    if (rd_acc && st_q.pready) begin
      st_d.prdata = 32'h0000_0000;
    end else if (psel && !penable) begin
      case (paddr)
        `OFS_CONTROL_ONE: st_d.prdata = {16'h0000, st_q.control_one};
        `OFS_CONTROL_TWO: st_d.prdata = {16'h0000, st_q.control_two};
        `OFS_IRQ_DMA_ENABLE: st_d.prdata = {16'h0000, st_q.irq_dma_enable};
        `OFS_STATUS_FLAGS: st_d.prdata = {31'h0000_0000, st_q.update_flag};
        `OFS_EVENT_GENERATE: st_d.prdata = 32'h0000_0000;
        `OFS_COUNTER_VALUE: st_d.prdata = {16'h0000, st_q.counter_value};
        `OFS_PRESCALE_VALUE: st_d.prdata = {16'h0000, st_q.prescale_value};
        `OFS_RELOAD_VALUE: st_d.prdata = {16'h0000, st_q.reload_value};
        default: st_d.prdata = 32'h0000_0000;
      endcase
      // unmapped reads and writes flagged here so pslverr stands with pready
      if ((paddr != `OFS_CONTROL_ONE) && (paddr != `OFS_CONTROL_TWO) &&
          (paddr != `OFS_IRQ_DMA_ENABLE) && (paddr != `OFS_STATUS_FLAGS) &&
          (paddr != `OFS_EVENT_GENERATE) && (paddr != `OFS_COUNTER_VALUE) &&
          (paddr != `OFS_PRESCALE_VALUE) && (paddr != `OFS_RELOAD_VALUE)) begin
        st_d.pslverr = 1'b1;
      end
    end

    // update event: buffers reload, counter cleared on force
    if (update_event_pulse) begin
      st_d.prescale_active = st_q.prescale_value;
      st_d.reload_active = st_q.reload_value;
      if (soft_update) begin
        st_d.counter_value = 16'h0000;
      end
      if (st_q.control_one[`BIT_ONE_SHOT_ENABLE]) begin
        st_d.control_one[`BIT_COUNT_ENABLE] = 1'b0;
      end
    end

    // hardware set wins over a software clear
    if (update_request) begin
      st_d.update_flag = 1'b1;
    end

    st_d.irq = st_d.update_flag && st_q.irq_dma_enable[`BIT_UPDATE_IRQ_ENABLE];
    st_d.dma_req = update_request && st_q.irq_dma_enable[`BIT_UPDATE_DMA_ENABLE];

    // trigger source select; reserved codes drive low
    case (mo_sel)
      mo_reset: st_d.trigger_output = st_q.reset_pulse;
      mo_enable: st_d.trigger_output = st_q.control_one[`BIT_COUNT_ENABLE];
      mo_update: st_d.trigger_output = update_event_pulse;
      default: st_d.trigger_output = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= '0;
      st_q.reload_value <= `RST_RELOAD_VALUE;
      st_q.reload_active <= `RST_RELOAD_VALUE;
    end else begin
      st_q <= st_d;
    end
  end

  assign prdata = st_q.prdata;
  assign pready = st_q.pready;
  assign pslverr = st_q.pslverr;
  assign irq = st_q.irq;
  assign dma_req = st_q.dma_req;
  assign trigger_output = st_q.trigger_output;

  // overflow wraps counter to zero next cycle
  a_wrap_to_zero: assert property (@(posedge pclk) disable iff (!presetn)
    overflow && !wr_acc |=> st_q.counter_value == 16'h0000)
    else $error("counter did not wrap on overflow");

  a_update_disable: assert property (@(posedge pclk) disable iff (!presetn)
    st_q.control_one[`BIT_UPDATE_DISABLE] |-> !update_event_pulse)
    else $error("update event while disabled");

  // software update with source select raises no flag
  a_source_select: assert property (@(posedge pclk) disable iff (!presetn)
    soft_update && !overflow && st_q.control_one[`BIT_UPDATE_SOURCE_SELECT] &&
    !st_q.update_flag && !(wr_acc && paddr == `OFS_STATUS_FLAGS) |=> !st_q.update_flag)
    else $error("flag set by software update despite source select");

  // one shot clears enable after update
  a_one_shot_stop: assert property (@(posedge pclk) disable iff (!presetn)
    update_event_pulse && st_q.control_one[`BIT_ONE_SHOT_ENABLE] && !wr_acc
    |=> !st_q.control_one[`BIT_COUNT_ENABLE])
    else $error("one shot did not stop counter");

  // flag set one cycle after qualifying event
  a_flag_set: assert property (@(posedge pclk) disable iff (!presetn)
    update_request |=> st_q.update_flag)
    else $error("update flag not set");

  // force update self clears and zeroes counter
  a_force_clear: assert property (@(posedge pclk) disable iff (!presetn)
    soft_update && !st_q.control_one[`BIT_UPDATE_DISABLE] && !wr_acc
    |=> !st_q.force_update && st_q.counter_value == 16'h0000)
    else $error("force update did not clear counter");

  a_zero_reload: assert property (@(posedge pclk) disable iff (!presetn)
    st_q.reload_active == 16'h0000 && !wr_acc && !soft_update
    |=> $stable(st_q.counter_value))
    else $error("counter moved with zero reload");

  a_irq_level: assert property (@(posedge pclk) disable iff (!presetn)
    irq == (st_q.update_flag && $past(st_q.irq_dma_enable[`BIT_UPDATE_IRQ_ENABLE])))
    else $error("irq level mismatch");

  a_enable_gate: assert property (@(posedge pclk) disable iff (!presetn)
    !st_q.control_one[`BIT_COUNT_ENABLE] |-> !count_tick)
    else $error("tick while count disabled");

  a_err_with_ready: assert property (@(posedge pclk) disable iff (!presetn)
    pslverr |-> pready)
    else $error("error response without ready");
endmodule

// [verification/basic_up_timer_test.sv]
`timescale 1ns/1ps
`include "basic_up_timer_params.svh"
module basic_up_timer_test;
  import basic_up_timer_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic irq;
  logic dma_req;
  logic trigger_output;
  int errors = 0;
  int n_compared = 0;
  logic [31:0] rv;
  logic ev;
  int c;
  int p;
  int r;
  logic [11:0] ofs[8];
  logic [31:0] rst[8];

  // free running bus clock, 8 ns period
  always #4 pclk = ~pclk;

  basic_up_timer uut (
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .irq(irq),
    .dma_req(dma_req),
    .trigger_output(trigger_output)
  );

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // one apb transfer; request held until pready is seen at an edge
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] rd_data, output logic err);
    int n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    // a bus that never answers counts as a mismatch
    if (pready !== 1'b1) errors++;
    rd_data = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] x;
    logic e;
    xfer(1'b1, a, d, x, e);
  endtask

  task automatic rchk(input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] x;
    logic e;
    xfer(1'b0, a, 32'h0, x, e);
    chk(x, exp);
  endtask

  // cycles from one dma pulse to the next; bounded so a dead timer cannot hang
  task automatic gap(output int cyc);
    int n = 0;
    while (dma_req !== 1'b1 && n < 5000) begin
      @(posedge pclk);
      n++;
    end
    @(posedge pclk);
    cyc = 1;
    while (dma_req !== 1'b1 && cyc < 5000) begin
      @(posedge pclk);
      cyc++;
    end
  endtask

  // edges at which trigger_output is seen high in a short window
  task automatic pulse(output int cnt);
    cnt = 0;
    repeat (6) begin
      @(posedge pclk);
      if (trigger_output === 1'b1) cnt++;
    end
  endtask

  task automatic end_of_test();
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // watchdog, far beyond the expected run length
  initial begin
    repeat (40000) @(posedge pclk);
    errors++;
    end_of_test();
  end

  initial begin
    ofs = '{`OFS_CONTROL_ONE, `OFS_CONTROL_TWO, `OFS_IRQ_DMA_ENABLE, `OFS_STATUS_FLAGS,
            `OFS_EVENT_GENERATE, `OFS_COUNTER_VALUE, `OFS_PRESCALE_VALUE, `OFS_RELOAD_VALUE};
    rst = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0000ffff};
    void'($urandom(51));
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 8; i++) rchk(ofs[i], rst[i]);
    xfer(1'b0, 12'h008, 32'h0, rv, ev);
    chk({31'h0, ev}, 32'h1);
    chk(rv, 32'h0);
    xfer(1'b1, 12'h008, 32'h1, rv, ev);
    chk({31'h0, ev}, 32'h1);
    wr(`OFS_CONTROL_TWO, 32'hffffffff);
    rchk(`OFS_CONTROL_TWO, 32'h70);
    wr(`OFS_IRQ_DMA_ENABLE, 32'h0000ffff);
    rchk(`OFS_IRQ_DMA_ENABLE, 32'h101);
    wr(`OFS_CONTROL_TWO, 32'h0);
    // period check; first pass is the smallest legal case
    for (int i = 0; i < 5; i++) begin
      p = (i == 0) ? 0 : $urandom_range(0, 3);
      r = (i == 0) ? 1 : $urandom_range(1, 9);
      wr(`OFS_CONTROL_ONE, 32'h0);
      wr(`OFS_PRESCALE_VALUE, p);
      wr(`OFS_RELOAD_VALUE, r);
      wr(`OFS_IRQ_DMA_ENABLE, 32'h100);
      wr(`OFS_EVENT_GENERATE, 32'h1);
      wr(`OFS_CONTROL_ONE, 32'h1);
      gap(c);
      gap(c);
      chk(c, (p + 1) * (r + 1));
    end
    // flag, interrupt and source selection with the counter stopped
    wr(`OFS_CONTROL_ONE, 32'h0);
    wr(`OFS_STATUS_FLAGS, 32'h0);
    wr(`OFS_IRQ_DMA_ENABLE, 32'h1);
    wr(`OFS_COUNTER_VALUE, 32'h1234);
    rchk(`OFS_COUNTER_VALUE, 32'h1234);
    wr(`OFS_EVENT_GENERATE, 32'h1);
    rchk(`OFS_COUNTER_VALUE, 32'h0);
    rchk(`OFS_EVENT_GENERATE, 32'h0);
    rchk(`OFS_STATUS_FLAGS, 32'h1);
    chk({31'h0, irq}, 32'h1);
    wr(`OFS_STATUS_FLAGS, 32'h1);
    rchk(`OFS_STATUS_FLAGS, 32'h1);
    wr(`OFS_IRQ_DMA_ENABLE, 32'h0);
    rchk(`OFS_STATUS_FLAGS, 32'h1);
    chk({31'h0, irq}, 32'h0);
    wr(`OFS_STATUS_FLAGS, 32'h0);
    rchk(`OFS_STATUS_FLAGS, 32'h0);
    wr(`OFS_CONTROL_ONE, 32'h4);
    wr(`OFS_EVENT_GENERATE, 32'h1);
    rchk(`OFS_STATUS_FLAGS, 32'h0);
    wr(`OFS_CONTROL_ONE, 32'h2);
    wr(`OFS_EVENT_GENERATE, 32'h1);
    rchk(`OFS_STATUS_FLAGS, 32'h0);
    // one shot run with the enable level routed out
    wr(`OFS_CONTROL_ONE, 32'h0);
    wr(`OFS_CONTROL_TWO, 32'h10);
    wr(`OFS_PRESCALE_VALUE, 32'h1);
    wr(`OFS_RELOAD_VALUE, 32'h9);
    wr(`OFS_EVENT_GENERATE, 32'h1);
    wr(`OFS_CONTROL_ONE, 32'h9);
    repeat (3) @(posedge pclk);
    chk({31'h0, trigger_output}, 32'h1);
    repeat (40) @(posedge pclk);
    rchk(`OFS_CONTROL_ONE, 32'h8);
    chk({31'h0, trigger_output}, 32'h0);
    // trigger pulses for the update and reset selections
    wr(`OFS_CONTROL_TWO, 32'h20);
    wr(`OFS_EVENT_GENERATE, 32'h1);
    pulse(c);
    chk(c, 32'h1);
    wr(`OFS_CONTROL_TWO, 32'h0);
    wr(`OFS_EVENT_GENERATE, 32'h1);
    pulse(c);
    chk(c, 32'h1);
    // buffered reload: a zero write must wait for the next update
    wr(`OFS_CONTROL_ONE, 32'h81);
    wr(`OFS_RELOAD_VALUE, 32'h0);
    wr(`OFS_COUNTER_VALUE, 32'h5);
    repeat (4) @(posedge pclk);
    xfer(1'b0, `OFS_COUNTER_VALUE, 32'h0, rv, ev);
    chk({31'h0, rv != 32'h5}, 32'h1);
    // empty reload after the update keeps the counter still
    wr(`OFS_EVENT_GENERATE, 32'h1);
    wr(`OFS_COUNTER_VALUE, 32'h5);
    repeat (20) @(posedge pclk);
    rchk(`OFS_COUNTER_VALUE, 32'h5);
    end_of_test();
  end
endmodule
